//--- dv/sbc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_chk (
  // Clock, reset and inputs
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_dip_closed,
  input wire logic       i_priority_chain_in,
  input wire logic       i_io_cycle,
  input wire logic       i_ack_cycle,
  input wire logic       i_opcode_fetch_cycle,
  input wire logic       i_irq_ser1,
  input wire logic       i_irq_ser2,
  input wire logic       i_irq_timer,
  // Outputs watched
  input wire logic       o_int_req,
  input wire logic       o_priority_chain_out,
  input wire logic [2:0] o_ack_grant,
  input wire logic       o_snoop_fetch,
  input wire logic       o_wait72_out,
  input wire logic       o_wait72_oe_n,
  input wire logic       o_wait3_out,
  input wire logic       o_wait3_oe_n,
  input wire logic       o_timer_tick
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_wait_on;
    $fell(o_wait72_oe_n);
  endsequence
  sequence s_wait_off;
    ##[1:7] o_wait72_oe_n;
  endsequence
  a_int_switch: assert property (
    o_int_req |-> $past(i_dip_closed[7], 3)) else $error("int, switch open");
  a_int_source: assert property (
    o_int_req |-> $past(i_irq_ser1 || i_irq_ser2 || i_irq_timer, 3))
    else $error("int without source");
  a_int_chain: assert property (
    o_int_req |-> $past(i_priority_chain_in, 3)) else $error("int, chain low");
  a_chain_out: assert property (
    o_priority_chain_out |-> $past(i_priority_chain_in, 3))
    else $error("chain out without chain in");
  a_grant_one: assert property (
    $onehot0(o_ack_grant)) else $error("grant not one-hot");
  a_wait_oc: assert property (
    !o_wait72_out && !o_wait3_out) else $error("wait drives high");
  a_wait_single: assert property (
    o_wait72_oe_n || o_wait3_oe_n) else $error("both wait lines pulled");
  a_wait_len: assert property (
    s_wait_on |-> s_wait_off) else $error("wait held too long");
  a_wait_cause: assert property (
    s_wait_on |-> $past(i_io_cycle || i_ack_cycle, 3))
    else $error("wait outside bus cycle");
  a_snoop_src: assert property (
    o_snoop_fetch |-> $past(i_opcode_fetch_cycle || i_ack_cycle, 3))
    else $error("snoop without cause");
  a_tick_pulse: assert property (
    o_timer_tick |=> !o_timer_tick) else $error("tick longer than one");
endmodule
bind sbc_top sbc_chk u_chk (.*);
`default_nettype wire

//--- dv/sbc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_host (
  // Clock and bus lines
  input  wire logic       i_clk_sys,
  input  wire logic       i_wait_n,
  input  wire logic [2:0] i_grant,
  output var  logic [7:0] o_addr,
  output var  logic       o_io,
  output var  logic       o_ack
);
  int         waits;
  logic [2:0] grant;
  initial begin
    o_addr = 8'h00;
    o_io   = 1'b0;
    o_ack  = 1'b0;
  end
  // One bus cycle, held past the longest wait; counts wait cycles
  task automatic cycle(input logic ack, input logic [7:0] a);
    waits = 0;
    grant = 3'h0;
    o_addr <= a;
    o_io   <= !ack;
    o_ack  <= ack;
    repeat (16) begin
      @(posedge i_clk_sys);
      if (!i_wait_n) waits++;
      if (ack && i_grant != 3'h0) grant = i_grant;
    end
    o_io   <= 1'b0;
    o_ack  <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk_sys = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, err, i_io_cycle, i_ack_cycle, o_int_req;
  logic [7:0] i_dip_closed = 8'hF0, i_bus_addr;
  logic i_opcode_fetch_cycle = 0, i_irq_ser1 = 0, i_irq_ser2 = 0;
  logic i_irq_timer = 0, i_priority_chain_in = 1, o_priority_chain_out;
  logic [2:0] o_ack_grant, i_counter_out = 3'h5;
  logic o_snoop_fetch, o_board_sel, o_wait72_out, o_wait72_oe_n;
  logic o_wait3_out, o_wait3_oe_n, i_line_tick = 0, o_timer_tick;
  logic [3:0] i_link_receive_clock = 4'hA, i_link_transmit_clock = 4'h5;
  logic [3:0] o_ser_rx_clk, o_ser_tx_clk, e;
  int n_fail = 0, tests_run = 0, n3 = 0, g;
  always #5 i_clk_sys = ~i_clk_sys;
  always begin
    repeat (5) @(posedge i_clk_sys);
    i_line_tick <= ~i_line_tick;
  end
  always @(posedge i_clk_sys) if (!o_wait3_oe_n) n3++;
  sbc_top DUT (.*);
  sbc_host host (.i_clk_sys(i_clk_sys), .o_addr(i_bus_addr), .o_io(i_io_cycle),
    .i_wait_n((o_wait72_oe_n | o_wait72_out) & (o_wait3_oe_n | o_wait3_out)),
    .i_grant(o_ack_grant), .o_ack(i_ack_cycle));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, x);
    tests_run++;
    if (s !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      report_and_stop();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_clk_sys);
  endtask
  task automatic gap;
    int k = 0;
    while (o_timer_tick !== 1'b1 && k < 600) begin
      @(posedge i_clk_sys);
      k++;
    end
    g = 0;
    do begin
      @(posedge i_clk_sys);
      g++;
    end while (o_timer_tick !== 1'b1 && g < 600);
    if (k >= 600 || g >= 600) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1;
    @(posedge i_clk_sys);
    apb(0, 12'h000, 0);
    check("ctrl", rd, 32'h1);
    apb(0, 12'h004, 0);
    check("clksel", rd, 32'hA4);
    apb(0, 12'h020, 0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    check("rxclk", o_ser_rx_clk, 4'hD);
    apb(1, 12'h004, 32'hFF);
    repeat (4) @(posedge i_clk_sys);
    check("link", {o_ser_rx_clk, o_ser_tx_clk}, 8'hA5);
    for (int i = 0; i < 16; i += 5) begin
      e = {i[0], i[1], i[2], i[3]};
      i_dip_closed[3:0] <= i[3:0];
      repeat (3) @(posedge i_clk_sys);
      apb(0, 12'h00C, 0);
      check("base", rd[11:8], e);
      host.cycle(0, {e, 4'h3});
      check("io wait", host.waits, 1);
      check("board sel", o_board_sel, 1);
      host.cycle(0, {~e, 4'h3});
      check("miss", host.waits, 0);
      check("board off", o_board_sel, 0);
    end
    for (int c = 0; c < 8; c++) begin
      i_dip_closed[6:4] <= ~{c[0], c[1], c[2]};
      repeat (3) @(posedge i_clk_sys);
      host.cycle(1, 8'h00);
      check("ack wait", host.waits, 7 - c);
    end
    apb(1, 12'h000, 32'h3);
    g = n3;
    host.cycle(0, {e, 4'h0});
    check("pin3", n3 - g, 1);
    apb(1, 12'h000, 32'h0);
    host.cycle(0, {e, 4'h0});
    check("no wait", host.waits, 0);
    for (int p = 7; p > 0; p = p >> 1) begin
      {i_irq_ser1, i_irq_ser2, i_irq_timer} <= p[2:0];
      repeat (4) @(posedge i_clk_sys);
      check("int", o_int_req, 1);
      host.cycle(1, 8'h00);
      check("grant", host.grant, p[2:0] ^ (p[2:0] >> 1));
    end
    {i_irq_ser1, i_irq_ser2, i_irq_timer} <= 3'h7;
    apb(1, 12'h000, 32'h08);
    repeat (2) @(posedge i_clk_sys);
    host.cycle(1, 8'h00);
    check("grant ser2", host.grant, 3'h2);
    apb(1, 12'h000, 32'h10);
    host.cycle(1, 8'h00);
    check("grant timer", host.grant, 3'h1);
    {i_irq_ser1, i_irq_ser2, i_irq_timer} <= 3'h1;
    apb(1, 12'h000, 32'h0);
    i_dip_closed[7] <= 0;
    repeat (4) @(posedge i_clk_sys);
    check("masked", o_int_req, 0);
    i_dip_closed[7] <= 1;
    i_priority_chain_in <= 0;
    repeat (4) @(posedge i_clk_sys);
    check("chain lo", {o_int_req, o_priority_chain_out}, 0);
    i_irq_timer <= 0;
    i_priority_chain_in <= 1;
    i_opcode_fetch_cycle <= 1;
    repeat (4) @(posedge i_clk_sys);
    check("chain hi", {o_priority_chain_out, o_snoop_fetch}, 3);
    apb(1, 12'h000, 32'h4);
    repeat (3) @(posedge i_clk_sys);
    check("snoop ack", o_snoop_fetch, 0);
    apb(1, 12'h008, 32'h0302);
    apb(1, 12'h000, 32'h40);
    gap();
    check("clk mode", g, 6);
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h008, 32'h02FF);
    apb(1, 12'h000, 32'h60);
    gap();
    check("line mode", g, 20);
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- rtl/sbc_defines.vh
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define SBC_OFF_CTRL      12'h000
`define SBC_OFF_CLKSEL    12'h004
`define SBC_OFF_TIMER     12'h008
`define SBC_OFF_STATUS    12'h00C
`define SBC_OFF_TCOUNT    12'h010

// ****************************************
// Control fields
// ****************************************
`define SBC_CTRL_WAIT_EN  0
`define SBC_CTRL_WAIT_SEL 1
`define SBC_CTRL_SNOOP    2
`define SBC_CTRL_PRIO_LO  3
`define SBC_CTRL_PRIO_HI  4
`define SBC_CTRL_TMODE    5
`define SBC_CTRL_TRUN     6
`define SBC_CTRL_W        7

// ****************************************
// Reset values
// ****************************************
`define SBC_CTRL_RST      7'h01
`define SBC_CLKSEL_RST    8'hA4
`define SBC_PRESC_RST     8'hFF
`define SBC_TCONST_RST    8'hFF

// ****************************************
// Encodings and counts
// ****************************************
`define SBC_SRC_LINK      2'h3
`define SBC_PRIO_DEFAULT  2'h0
`define SBC_PRIO_SER2     2'h1
`define SBC_PRIO_TIMER    2'h2
`define SBC_WAIT_IO       3'h1
`define SBC_WAIT_BASE     3'h7
`define SBC_LINE_HZ       60

`endif

//--- rtl/sbc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.vh"

module sbc_top #(
  parameter WAIT_W = 3
) (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // Board switches, one = closed
  input  wire [7:0]  i_dip_closed,
  // System bus cycle status
  input  wire [7:0]  i_bus_addr,
  input  wire        i_io_cycle,
  input  wire        i_ack_cycle,
  input  wire        i_opcode_fetch_cycle,
  // On-board interrupt sources
  input  wire        i_irq_ser1,
  input  wire        i_irq_ser2,
  input  wire        i_irq_timer,
  // Board priority chain
  input  wire        i_priority_chain_in,
  output reg         o_priority_chain_out,
  output reg         o_int_req,
  output reg  [2:0]  o_ack_grant,
  output reg         o_snoop_fetch,
  output reg         o_board_sel,
  // Open-collector wait lines
  output reg         o_wait72_out,
  output reg         o_wait72_oe_n,
  output reg         o_wait3_out,
  output reg         o_wait3_oe_n,
  // Serial clock routing
  input  wire [2:0]  i_counter_out,
  input  wire [3:0]  i_link_receive_clock,
  input  wire [3:0]  i_link_transmit_clock,
  output reg  [3:0]  o_ser_rx_clk,
  output reg  [3:0]  o_ser_tx_clk,
  // Timer channel 3
  input  wire        i_line_tick,
  output reg         o_timer_tick
);

  // ****************************************
  // Functions
  // ****************************************
  function [8:0] full_count;
    input [7:0] v;
    begin
      full_count = (v == 8'h00) ? 9'h100 : {1'b0, v};
    end
  endfunction

  function clk_pick;
    input [1:0] sel;
    input [2:0] ctr;
    input       link;
    begin
      case (sel)
        2'h0:    clk_pick = ctr[0];
        2'h1:    clk_pick = ctr[1];
        2'h2:    clk_pick = ctr[2];
        default: clk_pick = link;
      endcase
    end
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam SYNC_W = 8 + 8 + 3 + 3 + 1 + 3 + 8 + 1;

  wire [SYNC_W-1:0] sync_in;
  reg  [SYNC_W-1:0] sync1_q;
  reg  [SYNC_W-1:0] sync2_q;

  assign sync_in = {i_dip_closed, i_bus_addr, i_io_cycle, i_ack_cycle,
                    i_opcode_fetch_cycle, i_irq_ser1, i_irq_ser2,
                    i_irq_timer, i_priority_chain_in, i_counter_out,
                    i_link_receive_clock, i_link_transmit_clock,
                    i_line_tick};

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= {SYNC_W{1'b0}};
      sync2_q <= {SYNC_W{1'b0}};
    end else begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  wire [7:0] sw     = sync2_q[34:27];
  wire [7:0] baddr  = sync2_q[26:19];
  wire       io_s   = sync2_q[18];
  wire       ack_s  = sync2_q[17];
  wire       fet_s  = sync2_q[16];
  wire [2:0] irq_s  = sync2_q[15:13];
  wire       chin_s = sync2_q[12];
  wire [2:0] ctr_s  = sync2_q[11:9];
  wire [3:0] lrx_s  = sync2_q[8:5];
  wire [3:0] ltx_s  = sync2_q[4:1];
  wire       tick_s = sync2_q[0];

  // ****************************************
  // Switch decode
  // ****************************************
  wire [3:0]        base_hi  = {sw[0], sw[1], sw[2], sw[3]};
  wire [2:0]        ack_code = ~{sw[4], sw[5], sw[6]};
  wire [WAIT_W-1:0] ack_wait = `SBC_WAIT_BASE - ack_code;
  wire              irq_en   = sw[7];

  // ****************************************
  // Registers
  // ****************************************
  reg  [`SBC_CTRL_W-1:0] ctrl_q;
  reg  [7:0]             clksel_q;
  reg  [7:0]             presc_q;
  reg  [7:0]             tconst_q;
  reg  [8:0]             tcount_q;
  reg  [8:0]             pcount_q;
  reg                    tick_prev_q;
  reg  [WAIT_W-1:0]      wcount_q;
  reg                    wait_q;
  reg                    cyc_prev_q;
  reg  [31:0]            rdata_d;
  reg                    rerr_d;

  wire apb_setup  = i_psel && !i_penable;
  wire apb_access = i_psel && i_penable && o_pready;
  wire apb_wr     = apb_access && i_pwrite;

  always @* begin
    rdata_d = 32'h00000000;
    rerr_d  = 1'b0;
    case (i_paddr)
      `SBC_OFF_CTRL:   rdata_d = {25'h0000000, ctrl_q};
      `SBC_OFF_CLKSEL: rdata_d = {24'h000000, clksel_q};
      `SBC_OFF_TIMER:  rdata_d = {16'h0000, tconst_q, presc_q};
      `SBC_OFF_STATUS: rdata_d = {13'h0000, irq_s, wait_q, ack_wait,
                                  base_hi, sw};
      `SBC_OFF_TCOUNT: rdata_d = {23'h000000, tcount_q};
      default:         rerr_d  = 1'b1;
    endcase
  end

  // APB answers one cycle after setup
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= apb_setup;
      o_pslverr <= apb_setup && rerr_d;
      if (apb_setup && !i_pwrite) begin
        o_prdata <= rdata_d;
      end
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q   <= `SBC_CTRL_RST;
      clksel_q <= `SBC_CLKSEL_RST;
      presc_q  <= `SBC_PRESC_RST;
      tconst_q <= `SBC_TCONST_RST;
    end else if (apb_wr) begin
      case (i_paddr)
        `SBC_OFF_CTRL:   ctrl_q   <= i_pwdata[`SBC_CTRL_W-1:0];
        `SBC_OFF_CLKSEL: clksel_q <= i_pwdata[7:0];
        `SBC_OFF_TIMER: begin
          presc_q  <= i_pwdata[7:0];
          tconst_q <= i_pwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Interrupt priority and chain
  // ****************************************
  wire [2:0] irq_g   = irq_s & {3{irq_en}};
  wire       any_irq = |irq_g;
  reg  [2:0] grant_d;

  always @* begin
    grant_d = 3'b000;
    case (ctrl_q[`SBC_CTRL_PRIO_HI:`SBC_CTRL_PRIO_LO])
      `SBC_PRIO_SER2: begin
        if (irq_g[1])      grant_d = 3'b010;
        else if (irq_g[2]) grant_d = 3'b100;
        else if (irq_g[0]) grant_d = 3'b001;
      end
      `SBC_PRIO_TIMER: begin
        if (irq_g[0])      grant_d = 3'b001;
        else if (irq_g[2]) grant_d = 3'b100;
        else if (irq_g[1]) grant_d = 3'b010;
      end
      default: begin
        if (irq_g[2])      grant_d = 3'b100;
        else if (irq_g[1]) grant_d = 3'b010;
        else if (irq_g[0]) grant_d = 3'b001;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int_req            <= 1'b0;
      o_priority_chain_out <= 1'b0;
      o_ack_grant          <= 3'b000;
      o_snoop_fetch        <= 1'b0;
      o_board_sel          <= 1'b0;
    end else begin
      o_int_req            <= any_irq && chin_s;
      o_priority_chain_out <= chin_s && !any_irq;
      o_ack_grant          <= (ack_s && chin_s) ? grant_d : 3'b000;
      o_snoop_fetch        <= ctrl_q[`SBC_CTRL_SNOOP] ? ack_s
                                                      : fet_s;
      o_board_sel          <= (baddr[7:4] == base_hi);
    end
  end

  // ****************************************
  // Wait state generator
  // ****************************************
  wire io_hit    = io_s && (baddr[7:4] == base_hi);
  wire cyc_now   = io_hit || (ack_s && chin_s);
  wire cyc_start = cyc_now && !cyc_prev_q;
  wire [WAIT_W-1:0] wneed = ack_s ? ack_wait : `SBC_WAIT_IO;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_prev_q <= 1'b0;
      wcount_q   <= {WAIT_W{1'b0}};
      wait_q     <= 1'b0;
    end else begin
      cyc_prev_q <= cyc_now;
      if (!cyc_now) begin
        wait_q   <= 1'b0;
        wcount_q <= {WAIT_W{1'b0}};
      end else if (cyc_start) begin
        wait_q   <= ctrl_q[`SBC_CTRL_WAIT_EN] &&
                    (wneed != {WAIT_W{1'b0}});
        wcount_q <= wneed;
      end else if (wcount_q != {WAIT_W{1'b0}}) begin
        wcount_q <= wcount_q - 1'b1;
        wait_q   <= wait_q && (wcount_q != 1);
      end
    end
  end

  // Open collector: enable low pulls line low
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wait72_out  <= 1'b0;
      o_wait72_oe_n <= 1'b1;
      o_wait3_out   <= 1'b0;
      o_wait3_oe_n  <= 1'b1;
    end else begin
      o_wait72_out  <= 1'b0;
      o_wait3_out   <= 1'b0;
      o_wait72_oe_n <= !(wait_q && !ctrl_q[`SBC_CTRL_WAIT_SEL]);
      o_wait3_oe_n  <= !(wait_q && ctrl_q[`SBC_CTRL_WAIT_SEL]);
    end
  end

  // ****************************************
  // Serial clock routing
  // ****************************************
  wire [1:0] src_a = clksel_q[1:0];
  wire [1:0] src_b = clksel_q[3:2];
  wire [1:0] src_c = clksel_q[5:4];
  wire [1:0] src_d = clksel_q[7:6];

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ser_rx_clk <= 4'h0;
      o_ser_tx_clk <= 4'h0;
    end else begin
      o_ser_rx_clk <= {clk_pick(src_d, ctr_s, lrx_s[3]),
                       clk_pick(src_c, ctr_s, lrx_s[2]),
                       clk_pick(src_b, ctr_s, lrx_s[1]),
                       clk_pick(src_a, ctr_s, lrx_s[0])};
      o_ser_tx_clk <= {clk_pick(src_d, ctr_s, ltx_s[3]),
                       clk_pick(src_c, ctr_s, ltx_s[2]),
                       clk_pick(src_b, ctr_s, ltx_s[1]),
                       clk_pick(src_a, ctr_s, ltx_s[0])};
    end
  end

  // ****************************************
  // Timer channel 3
  // ****************************************
  wire line_edge = tick_s && !tick_prev_q;
  wire pre_done  = (pcount_q == 9'h001);
  wire step      = ctrl_q[`SBC_CTRL_TMODE] ? line_edge
                                           : pre_done;
  wire running   = ctrl_q[`SBC_CTRL_TRUN];

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_prev_q  <= 1'b0;
      pcount_q     <= 9'h001;
      tcount_q     <= 9'h001;
      o_timer_tick <= 1'b0;
    end else begin
      tick_prev_q  <= tick_s;
      o_timer_tick <= 1'b0;
      if (!running) begin
        pcount_q <= full_count(presc_q);
        tcount_q <= full_count(tconst_q);
      end else begin
        pcount_q <= pre_done ? full_count(presc_q)
                             : pcount_q - 9'h001;
        if (step) begin
          if (tcount_q == 9'h001) begin
            tcount_q     <= full_count(tconst_q);
            o_timer_tick <= 1'b1;
          end else begin
            tcount_q <= tcount_q - 9'h001;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire
